// ### verilog/tmc_regs.svh
// Register offsets, field positions, reset values and counts for the timer.
// Assumes inclusion by bare name from package and design files.
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH
`define TMC_CTRL_OFS 4'h0
`define TMC_COUNT_LO_OFS 4'h4
`define TMC_COUNT_HI_OFS 4'h8
`define TMC_STATUS_OFS 4'hc
`define TMC_CTRL_ON_BIT 15
`define TMC_CTRL_IDLE_BIT 13
`define TMC_CTRL_GATE_BIT 6
`define TMC_CTRL_PS_HI 5
`define TMC_CTRL_PS_LO 4
`define TMC_CTRL_WIDE_BIT 3
`define TMC_CTRL_CS_BIT 1
`define TMC_CTRL_MASK 16'ha07a
`define TMC_CTRL_RST 16'h0000
`define TMC_DIV_1 9'h001
`define TMC_DIV_8 9'h008
`define TMC_DIV_64 9'h040
`define TMC_DIV_256 9'h100
`endif

// ### verilog/tmc_pkg.sv
// Types shared by the timer control files.
// Assumes tmc_regs.svh is on the include path.
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_PS_1 = 2'b00,
    TMC_PS_8 = 2'b01,
    TMC_PS_64 = 2'b10,
    TMC_PS_256 = 2'b11
  } tmc_ps_e;
  typedef enum logic [1:0] {
    TMC_BUS_IDLE = 2'b00,
    TMC_BUS_ACK = 2'b01
  } tmc_bus_e;
endpackage : tmc_pkg

// ### verilog/tmc_tick_if.sv
// Interface carrying the count tick between prescaler and counter.
// Assumes one clock domain.
`timescale 1ns/1ps
interface tmc_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : tmc_tick_if

// ### verilog/tmc_prescale.sv
// Prescaler: turns count-source events into ticks, divided by 1/8/64/256.
// Assumes events are one-cycle pulses on clock_i.
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tmc_prescale
  import tmc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Control
  input wire logic clear_i,
  input wire logic event_i,
  input wire tmc_ps_e ps_i,
  // Tick out
  tmc_tick_if.src tick_o
);
  logic [8:0] cnt_r;
  logic [8:0] div;
  logic tick_r;

  always_comb begin
    case (ps_i)
      TMC_PS_8: div = `TMC_DIV_8;
      TMC_PS_64: div = `TMC_DIV_64;
      TMC_PS_256: div = `TMC_DIV_256;
      default: div = `TMC_DIV_1;
    endcase
  end

  // A cleared prescaler restarts from zero so a new ratio takes clean effect.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 9'h000;
      tick_r <= 1'b0;
    end else if (clear_i) begin
      cnt_r <= 9'h000;
      tick_r <= 1'b0;
    end else if (event_i) begin
      if (cnt_r == div - 9'h001) begin
        cnt_r <= 9'h000;
        tick_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 9'h001;
        tick_r <= 1'b0;
      end
    end else begin
      tick_r <= 1'b0;
    end
  end

  assign tick_o.tick = tick_r;
endmodule : tmc_prescale

// ### verilog/tmc_timer.sv
// Timer control top: control register, clock select, gating, 16/32 count.
// Assumes Avalon-MM master, pins synchronous to clock_i.
//
// Contract
// - Run bit starts and stops counting, whole pair in wide mode.
// - Idle-stop bit set halts the timer while the device idles.
// - Gate enable accumulates while gate pin high, internal clock only.
// - Prescale codes 11,10,01,00 divide by 256, 64, 8 and 1.
// - Wide mode bit joins this timer and its neighbour as 32 bits.
// - Clock source bit picks external rising edges or instruction clock.
`timescale 1ns/1ps
`include "tmc_regs.svh"
module tmc_timer
  import tmc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Device state and pins
  input wire logic idle_i,
  input wire logic instruction_clock_i,
  input wire logic ext_timer_clock_pin_i,
  input wire logic gate_pin_i,
  // Timer outputs
  output logic [31:0] count_o,
  output logic running_o
);
  // ==========================================================
  // Register bus
  logic [15:0] ctrl_r;
  logic [31:0] count_r;
  logic [31:0] rdata_r;
  logic wait_r;
  tmc_bus_e bus_r;
  logic req;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic [31:0] rsel;

  assign req = avs_read_i | avs_write_i;
  // Every request answers on the cycle after it is seen.
  assign wr_ctrl = avs_write_i && bus_r == TMC_BUS_IDLE &&
                   avs_address_i == `TMC_CTRL_OFS;
  assign wr_lo = avs_write_i && bus_r == TMC_BUS_IDLE &&
                 avs_address_i == `TMC_COUNT_LO_OFS;
  assign wr_hi = avs_write_i && bus_r == TMC_BUS_IDLE &&
                 avs_address_i == `TMC_COUNT_HI_OFS;

  always_comb begin
    if (avs_address_i == `TMC_CTRL_OFS) begin
      rsel = {16'h0000, ctrl_r};
    end else if (avs_address_i == `TMC_COUNT_LO_OFS) begin
      rsel = {16'h0000, count_r[15:0]};
    end else if (avs_address_i == `TMC_COUNT_HI_OFS) begin
      rsel = {16'h0000, count_r[31:16]};
    end else if (avs_address_i == `TMC_STATUS_OFS) begin
      rsel = {31'h00000000, running_o};
    end else begin
      rsel = 32'h00000000;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_r <= TMC_BUS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      case (bus_r)
        TMC_BUS_IDLE: begin
          if (req) begin
            bus_r <= TMC_BUS_ACK;
            wait_r <= 1'b0;
            rdata_r <= avs_read_i ? rsel : 32'h00000000;
          end
        end
        default: begin
          bus_r <= TMC_BUS_IDLE;
          wait_r <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Control register
  logic [15:0] ctrl_mask;
  assign ctrl_mask = `TMC_CTRL_MASK;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= `TMC_CTRL_RST;
    end else if (wr_ctrl) begin
      if (avs_byteenable_i[0]) begin
        ctrl_r[7:0] <= avs_writedata_i[7:0] & ctrl_mask[7:0];
      end
      if (avs_byteenable_i[1]) begin
        ctrl_r[15:8] <= avs_writedata_i[15:8] & ctrl_mask[15:8];
      end
    end
  end

  // ==========================================================
  // Count source selection
  logic ext_d_r;
  logic ext_rise;
  logic src_event;
  logic run;
  logic gate_ok;
  logic clr_ps;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_timer_clock_pin_i;
    end
  end
  assign ext_rise = ext_timer_clock_pin_i & ~ext_d_r;

  // Gating applies only to the internal clock; external ignores it.
  assign gate_ok = ctrl_r[`TMC_CTRL_CS_BIT] |
                   ~ctrl_r[`TMC_CTRL_GATE_BIT] | gate_pin_i;
  assign run = ctrl_r[`TMC_CTRL_ON_BIT] &
               ~(ctrl_r[`TMC_CTRL_IDLE_BIT] & idle_i);
  assign src_event = run & gate_ok &
                     (ctrl_r[`TMC_CTRL_CS_BIT] ? ext_rise
                      : instruction_clock_i);
  assign clr_ps = ~ctrl_r[`TMC_CTRL_ON_BIT] | wr_ctrl;

  tmc_tick_if tick_bus ();

  tmc_prescale u_prescale (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .clear_i(clr_ps),
    .event_i(src_event),
    .ps_i(tmc_ps_e'(ctrl_r[`TMC_CTRL_PS_HI:`TMC_CTRL_PS_LO])),
    .tick_o(tick_bus.src)
  );

  // ==========================================================
  // Counter
  // In 16-bit mode the upper half belongs to the neighbour and holds still.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_r <= 32'h00000000;
    end else if (wr_lo) begin
      count_r[15:0] <= avs_writedata_i[15:0];
    end else if (wr_hi) begin
      count_r[31:16] <= avs_writedata_i[15:0];
    end else if (tick_bus.tick) begin
      if (ctrl_r[`TMC_CTRL_WIDE_BIT]) begin
        count_r <= count_r + 32'h00000001;
      end else begin
        count_r[15:0] <= count_r[15:0] + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      running_o <= 1'b0;
    end else begin
      running_o <= run;
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign count_o = count_r;
endmodule : tmc_timer

// ### dv/tmc_pins_model.sv
// Far-side model: instruction clock pulses and external clock pin.
// Assumes en_i and per_i change just after a rising edge.
`timescale 1ns/1ps
// ====
// Pin model
module tmc_pins_model (
  // Clock and control
  input wire logic clock_i,
  input wire logic en_i,
  input wire logic [1:0] per_i,
  // Pins
  output logic icl_o = 1'b0,
  output logic ext_o = 1'b0
);
  logic [1:0] n_r = 2'h0;
  // Both pins rest low when off, so no stray edge is counted.
  always @(posedge clock_i) begin
    n_r <= (n_r >= per_i) ? 2'h0 : n_r + 2'h1;
    icl_o <= en_i & (n_r == 2'h0);
    ext_o <= en_i & (ext_o ^ (n_r == 2'h0));
  end
endmodule : tmc_pins_model

// ### dv/tmc_timer_properties.sv
// Checker of the timer top ports, bound to tmc_timer.
// Assumes no software write to the count words.
`timescale 1ns/1ps
// ====
// Checker
module tmc_timer_properties (
  // Clock, reset and bus
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Pins and results
  input wire logic idle_i,
  input wire logic gate_pin_i,
  input wire logic [31:0] count_o,
  input wire logic running_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  logic [15:0] ctrl_r;
  logic [15:0] lanes;
  logic take;
  logic run_exp;
  assign lanes = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign take = avs_write_i & avs_waitrequest_o & (avs_address_i == 4'h0);
  assign run_exp = ctrl_r[15] & ~(idle_i & ctrl_r[13]);
  // Mirror of control; a write lands only on its take edge.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r <= 16'h0000;
    end else if (take) begin
      ctrl_r <= (ctrl_r & ~lanes) | (avs_writedata_i[15:0] & lanes & 16'ha07a);
    end
  end
  sequence ans_s;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  chk_bus_answer: assert property (($rose(avs_read_i) || $rose(avs_write_i))
    |=> ans_s) else $error("bus answer late or long");
  chk_ctrl_read: assert property (avs_read_i && !avs_waitrequest_o &&
    avs_address_i == 4'h0 |-> avs_readdata_o == {16'h0, ctrl_r})
    else $error("control read mismatch");
  chk_run_state: assert property ($stable(run_exp) [*2]
    |-> running_o == run_exp) else $error("running flag wrong");
  chk_stop_hold: assert property (!running_o [*3] |=> $stable(count_o))
    else $error("count moved while stopped");
  chk_narrow_hold: assert property (!ctrl_r[3] |=>
    count_o[31:16] == $past(count_o[31:16])) else $error("upper half moved");
  chk_step_gap: assert property ($changed(count_o) && ctrl_r[5:4] != 2'h0
    |=> $stable(count_o) [*6]) else $error("divided count too fast");
  chk_gate_block: assert property ((ctrl_r[6] && !ctrl_r[1] &&
    !gate_pin_i) [*5] |=> $stable(count_o)) else $error("gate ignored");
endmodule : tmc_timer_properties
bind tmc_timer tmc_timer_properties u_chk (.*);

// ### dv/tmc_timer_tb.sv
// Bench for tmc_timer: bus tasks, pin model and a counting model.
// Assumes the pin model and the checker are compiled first.
`timescale 1ns/1ps
// ====
// Bench
module tmc_timer_tb;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o, count_o, q, r;
  logic avs_waitrequest_o, running_o, en = 1'b0, cs = 1'b0, ge = 1'b0;
  logic idle_i = 1'b0, gate_pin_i = 1'b0, ext_q = 1'b0;
  logic instruction_clock_i, ext_timer_clock_pin_i;
  logic [1:0] per = 2'h0;
  integer n_mismatch = 0, checks_done = 0, cyc = 0, ev = 0, expc = 0;
  integer seed = 32'hff9b;
  integer div [4] = '{1, 8, 64, 256};
  initial forever #20 clock_i = ~clock_i;
  tmc_timer uut (.*);
  tmc_pins_model pins (.clock_i(clock_i), .en_i(en), .per_i(per),
    .icl_o(instruction_clock_i), .ext_o(ext_timer_clock_pin_i));
  // Counting model: source events as the timer samples them.
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    ev = ev + (cs ? (ext_timer_clock_pin_i & ~ext_q)
      : (instruction_clock_i & (gate_pin_i | ~ge)));
    ext_q = ext_timer_clock_pin_i;
    if (cyc == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_read_i <= ~w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // A control write clears the prescaler, so each run starts clean.
  task automatic seg(input logic [15:0] c, input logic g, input logic i);
    bus(1'b1, 4'h0, {16'h0, c});
    cs = c[1];
    ge = c[6];
    gate_pin_i <= g;
    idle_i <= i;
    per <= 2'({$random(seed)} % 3);
    ev = 0;
    en <= 1'b1;
    repeat (900 + {$random(seed)} % 300) @(posedge clock_i);
    en <= 1'b0;
    repeat (8) @(posedge clock_i);
    if (c[15] && !(i && c[13])) expc = expc + ev / div[c[5:4]];
    cmp(count_o, expc);
  endtask : seg
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    cmp(q, 32'h0);
    bus(1'b1, 4'h0, 32'hffff_ffff);
    bus(1'b1, 4'h6, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    cmp(q, 32'ha07a);
    bus(1'b0, 4'h6, 32'h0);
    cmp(q, 32'h0);
    r = $random(seed);
    bus(1'b1, 4'h0, r);
    bus(1'b0, 4'h0, 32'h0);
    cmp(q, r & 32'ha07a);
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 2; s++) begin
        seg(16'(32'h8000 | (p << 4) | (s * 10)), 1'b0, 1'b0);
      end
    end
    seg(16'h8040, 1'b0, 1'b0);
    seg(16'h8040, 1'b1, 1'b0);
    seg(16'h8042, 1'b0, 1'b0);
    seg(16'ha000, 1'b0, 1'b1);
    seg(16'h8000, 1'b0, 1'b1);
    seg(16'h0008, 1'b1, 1'b0);
    finish_test();
  end
endmodule : tmc_timer_tb
